// ===== ioe_host.sv
// Purpose: Bus master issuing single-byte register accesses
// Assumes: Only master on the bus, no clock stretching
// Notes:   Reads end with a not-acknowledge and a stop

`timescale 1ns/1ps

module ioe_host
  import ioe_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  ioe_bus_if.host         bus,
  input  wire logic       req_i,
  input  wire logic       read_i,
  input  wire logic       keep_ptr_i,
  input  wire logic [2:0] dev_addr_i,
  input  wire logic [1:0] reg_sel_i,
  input  wire logic [7:0] wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rdata_o
);

  // ****************************************
  // State
  // ****************************************
  ioe_host_st_e st_r;
  ioe_step_e    step_r;
  logic [4:0]   q_cnt_r;
  logic [1:0]   ph_r;
  logic [3:0]   bit_r;
  logic         rd_r;
  logic         keep_r;
  logic [2:0]   addr_r;
  logic [1:0]   sel_r;
  logic [7:0]   wd_r;
  logic [7:0]   rx_r;
  logic         scl_oe_n_r;
  logic         sda_oe_n_r;
  logic         nack_r;
  logic         done_r;
  logic         busy_r;

  // ****************************************
  // Decode
  // ****************************************
  wire        tick     = (q_cnt_r == QTR_CYC - 5'd1);
  wire        ph_end   = tick && (ph_r == PH_LAST);
  wire        is_rx    = (step_r == ST_RDATA);
  wire [7:0]  addr_w   = {ADDR_FIXED, addr_r, 1'b0};
  wire [7:0]  addr_rd  = {ADDR_FIXED, addr_r, 1'b1};
  wire [7:0]  tx_byte  = (step_r == ST_ADDR_W) ? addr_w :
                         (step_r == ST_CMD)    ? {6'h00, sel_r} :
                         (step_r == ST_WDATA)  ? wd_r : addr_rd;
  wire [2:0]  bit_idx  = 3'(4'd7 - bit_r);
  // Single byte reads: the ack slot is left released as a nack
  wire        tx_bit   = (bit_r == ACK_SLOT) || is_rx || tx_byte[bit_idx];
  wire        ack_seen = !bus.sda;
  wire        last_byt = (step_r == ST_WDATA) || is_rx;

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = scl_oe_n_r;
  assign bus.host_sda_oe_n = sda_oe_n_r;
  assign busy_o  = busy_r;
  assign done_o  = done_r;
  assign nack_o  = nack_r;
  assign rdata_o = rx_r;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r       <= HS_IDLE;
      step_r     <= ST_ADDR_W;
      q_cnt_r    <= 5'h00;
      ph_r       <= 2'h0;
      bit_r      <= 4'h0;
      rd_r       <= 1'b0;
      keep_r     <= 1'b0;
      addr_r     <= 3'h0;
      sel_r      <= 2'h0;
      wd_r       <= 8'h00;
      rx_r       <= 8'h00;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      nack_r     <= 1'b0;
      done_r     <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      done_r  <= 1'b0;
      q_cnt_r <= (st_r == HS_IDLE || tick) ? 5'h00 : q_cnt_r + 5'd1;
      if (tick) begin
        ph_r <= ph_r + 2'd1;
      end
      case (st_r)
        HS_IDLE: begin
          ph_r <= 2'h0;
          if (req_i) begin
            rd_r   <= read_i;
            keep_r <= keep_ptr_i;
            addr_r <= dev_addr_i;
            sel_r  <= reg_sel_i;
            wd_r   <= wdata_i;
            nack_r <= 1'b0;
            busy_r <= 1'b1;
            // Reading with the stored pointer skips the command byte
            step_r <= (read_i && keep_ptr_i) ? ST_ADDR_R : ST_ADDR_W;
            st_r   <= HS_START;
          end
        end
        // Start or repeated start: release, clock high, data low, clock low
        HS_START: begin
          if (tick) begin
            case (ph_r)
              2'h0: sda_oe_n_r <= 1'b1;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b0;
              default: begin
                scl_oe_n_r <= 1'b0;
                bit_r      <= 4'h0;
                st_r       <= HS_BIT;
              end
            endcase
          end
        end
        HS_BIT: begin
          if (tick) begin
            case (ph_r)
              2'h0: sda_oe_n_r <= tx_bit;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: begin
                if (is_rx && bit_r != ACK_SLOT) begin
                  rx_r <= {rx_r[6:0], bus.sda};
                end
              end
              default: scl_oe_n_r <= 1'b0;
            endcase
          end
          if (ph_end) begin
            bit_r <= bit_r + 4'd1;
            if (bit_r == ACK_SLOT) begin
              if (!is_rx && !ack_seen) begin
                nack_r <= 1'b1;
                st_r   <= HS_STOP;
              end else if (last_byt) begin
                st_r <= HS_STOP;
              end else if (step_r == ST_ADDR_W) begin
                step_r <= ST_CMD;
                bit_r  <= 4'h0;
              end else if (step_r == ST_CMD) begin
                bit_r  <= 4'h0;
                step_r <= rd_r ? ST_ADDR_R : ST_WDATA;
                st_r   <= rd_r ? HS_START : HS_BIT;
              end else begin
                step_r <= ST_RDATA;
                bit_r  <= 4'h0;
              end
            end
          end
        end
        HS_STOP: begin
          if (tick) begin
            case (ph_r)
              2'h0: sda_oe_n_r <= 1'b0;
              2'h1: scl_oe_n_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b1;
              default: st_r <= HS_DONE;
            endcase
          end
        end
        default: begin
          done_r <= 1'b1;
          busy_r <= 1'b0;
          st_r   <= HS_IDLE;
        end
      endcase
    end
  end

endmodule : ioe_host

// ===== ioe_pkg.sv
// Purpose: Shared constants and types for the serial 8-bit port expander
// Assumes: One 25 MHz clock on both ends
// Notes:   Register selects, reset values and bus timing live here

package ioe_pkg;

  // ****************************************
  // Addressing and command decode
  // ****************************************
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [1:0] SEL_INPUT  = 2'h0;
  localparam logic [1:0] SEL_OUTPUT = 2'h1;
  localparam logic [1:0] SEL_INVERT = 2'h2;
  localparam logic [1:0] SEL_DIR    = 2'h3;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [1:0] PH_LAST    = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_OUTPUT = 8'hff;
  localparam logic [7:0] RST_INVERT = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'hff;
  localparam logic [7:0] RST_PTR    = 8'h00;

  // ****************************************
  // Bus timing
  // ****************************************
  localparam int         CLK_HZ     = 25000000;
  localparam int         SCL_HZ     = 400000;
  localparam int         QTR_INT    = CLK_HZ / (4 * SCL_HZ);
  localparam logic [4:0] QTR_CYC    = 5'(QTR_INT);

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_CMD, DS_WDATA, DS_RDATA
  } ioe_dev_st_e;

  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_BIT, HS_STOP, HS_DONE
  } ioe_host_st_e;

  typedef enum logic [2:0] {
    ST_ADDR_W, ST_CMD, ST_WDATA, ST_ADDR_R, ST_RDATA
  } ioe_step_e;

endpackage : ioe_pkg

// ===== ioe_bus_if.sv
// Purpose: Two-wire bus joining host end and device end
// Assumes: Open-drain lines with pullups, modelled as wired-and
// Notes:   Output enables are active low

`timescale 1ns/1ps

interface ioe_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // ****************************************
  // Line resolution
  // ****************************************
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n,
    input  scl,
    input  sda
  );

  modport dev (
    output dev_sda_o,
    output dev_sda_oe_n,
    input  scl,
    input  sda
  );
endinterface : ioe_bus_if

// ===== ioe_dev.sv
// Purpose: Serial-bus 8-bit port expander, device end
// Assumes: Bus lines and port pins synchronous to clock_i
// Notes:   No clock stretching; acks driven on falling clock edges

`timescale 1ns/1ps

module ioe_dev
  import ioe_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  ioe_bus_if.dev          bus,
  input  wire logic [2:0] addr_strap_i,
  input  wire logic [7:0] port_i,
  output logic [7:0]      port_o,
  output logic [7:0]      port_oe_n_o,
  output logic            int_oe_n_o
);

  // ****************************************
  // Line synchronisers and edge detect
  // ****************************************
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], bus.scl};
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  // Start and stop are data edges while the clock stays high
  wire start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ****************************************
  // Registers
  // ****************************************
  ioe_dev_st_e st_r;
  logic [3:0]  bit_r;
  logic [7:0]  rx_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic [7:0]  out_r;
  logic [7:0]  inv_r;
  logic [7:0]  dir_r;
  logic [7:0]  snap_r;
  logic        snap_vld_r;
  logic        sda_oe_n_r;
  logic        int_oe_n_r;

  // ****************************************
  // Decode
  // ****************************************
  wire [1:0] sel      = ptr_r[1:0];
  wire [7:0] in_view  = port_i ^ inv_r;
  wire [7:0] rd_val   = (sel == SEL_INPUT)  ? in_view :
                        (sel == SEL_OUTPUT) ? out_r :
                        (sel == SEL_INVERT) ? inv_r : dir_r;
  wire       addr_hit = (rx_r[7:1] == {ADDR_FIXED, addr_strap_i});
  wire       rw_read  = rx_r[0];
  wire       ack_slot = (bit_r == ACK_SLOT);
  wire       ack_rise = scl_rise && ack_slot;
  wire       ack_fall = scl_fall && ack_slot;
  wire       need_ack = (st_r == DS_CMD) || (st_r == DS_WDATA) ||
                        ((st_r == DS_ADDR) && addr_hit);
  wire       rd_input = ack_rise && (st_r == DS_RDATA) && (sel == SEL_INPUT);
  wire       wr_data  = ack_rise && (st_r == DS_WDATA);
  // Only input-mode pins can raise the interrupt
  wire [7:0] changed  = (port_i ^ snap_r) & dir_r;
  wire       int_nxt  = snap_vld_r && !rd_input && (|changed);

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = sda_oe_n_r;
  assign port_o      = out_r;
  assign port_oe_n_o = dir_r;
  assign int_oe_n_o  = int_oe_n_r;

  // ****************************************
  // Protocol engine
  // ****************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r       <= DS_IDLE;
      bit_r      <= 4'h0;
      rx_r       <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= RST_PTR;
      sda_oe_n_r <= 1'b1;
    end else if (start_ev) begin
      // Repeated start leaves the pointer untouched
      st_r       <= DS_ADDR;
      bit_r      <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_ev) begin
      st_r       <= DS_IDLE;
      sda_oe_n_r <= 1'b1;
    end else if (st_r != DS_IDLE) begin
      if (scl_rise) begin
        if (!ack_slot) begin
          rx_r  <= {rx_r[6:0], sda_s};
          tx_r  <= {tx_r[6:0], 1'b1};
          bit_r <= bit_r + 4'd1;
        end else begin
          bit_r <= 4'h0;
          case (st_r)
            DS_ADDR: begin
              st_r <= rw_read ? DS_RDATA : DS_CMD;
              tx_r <= rd_val;
            end
            DS_CMD: begin
              ptr_r <= rx_r;
              st_r  <= DS_WDATA;
            end
            DS_WDATA: st_r <= DS_WDATA;
            default: begin
              // Not-acknowledge from the master ends the read
              if (sda_s) begin
                st_r <= DS_IDLE;
              end
              tx_r <= rd_val;
            end
          endcase
        end
      end else if (ack_fall) begin
        sda_oe_n_r <= !need_ack;
        if (st_r == DS_ADDR && !addr_hit) begin
          st_r <= DS_IDLE;
        end
      end else if (scl_fall) begin
        sda_oe_n_r <= (st_r == DS_RDATA) ? tx_r[7] : 1'b1;
      end
    end
  end

  // ****************************************
  // Register file writes
  // ****************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_r <= RST_OUTPUT;
      inv_r <= RST_INVERT;
      dir_r <= RST_DIR;
    end else if (wr_data) begin
      // Data taken at the acknowledge clock rise; input register ignores it
      case (sel)
        SEL_OUTPUT: out_r <= rx_r;
        SEL_INVERT: inv_r <= rx_r;
        SEL_DIR:    dir_r <= rx_r;
        default:    out_r <= out_r;
      endcase
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // Reference levels are caught one cycle after reset release, since
  // an async reset cannot load pin values
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap_r     <= 8'h00;
      snap_vld_r <= 1'b0;
      int_oe_n_r <= 1'b1;
    end else begin
      int_oe_n_r <= !int_nxt;
      if (!snap_vld_r || rd_input) begin
        snap_r     <= port_i;
        snap_vld_r <= 1'b1;
      end
    end
  end

endmodule : ioe_dev

// ===== ioe_monitor.sv
// Purpose: Checker on the shared two-wire link
// Assumes: One clock domain, async active-low reset
// Notes:   Bit and byte position rebuilt from the lines

`timescale 1ns/1ps

module ioe_monitor
  import ioe_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       host_scl_o,
  input wire logic       host_sda_o,
  input wire logic       dev_sda_o,
  input wire logic       dev_sda_oe_n,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic [2:0] addr_strap_i
);
  // ****************************************
  // Frame tracking
  // ****************************************
  logic       scl_q;
  logic       sda_q;
  logic       dat_r;
  logic       aok_r;
  logic       rw_r;
  logic [3:0] bitc_r;
  logic [7:0] sh_r;
  wire        rise     = scl & ~scl_q;
  wire        start    = scl & scl_q & sda_q & ~sda;
  wire        stop     = scl & scl_q & ~sda_q & sda;
  wire        ack      = rise & (bitc_r == ACK_SLOT);
  wire        addr_hit = sh_r[7:1] == {ADDR_FIXED, addr_strap_i};

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Counting from the line edges, not the design state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bitc_r <= 4'h0;
      dat_r  <= 1'b0;
      sh_r   <= 8'h00;
    end else if (start) begin
      bitc_r <= 4'h0;
      dat_r  <= 1'b0;
    end else if (ack) begin
      bitc_r <= 4'h0;
      dat_r  <= 1'b1;
    end else if (rise) begin
      bitc_r <= bitc_r + 4'h1;
      sh_r   <= {sh_r[6:0], sda};
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aok_r <= 1'b0;
      rw_r  <= 1'b0;
    end else if (ack && !dat_r) begin
      aok_r <= addr_hit;
      rw_r  <= sh_r[0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  addr_match_a: assert property (ack && !dat_r && addr_hit |-> !sda)
    else $error("own address not acknowledged");
  addr_other_a: assert property (ack && !dat_r && !addr_hit |-> dev_sda_oe_n)
    else $error("foreign address acknowledged");
  foreign_silent_a: assert property (dat_r && !aok_r |-> dev_sda_oe_n)
    else $error("line driven in foreign transfer");
  rx_ack_a: assert property (ack && dat_r && aok_r && !rw_r |-> !sda && !dev_sda_oe_n)
    else $error("received byte not acknowledged");
  host_ack_slot_a: assert property (ack && dat_r && rw_r |-> dev_sda_oe_n)
    else $error("line driven in host ack slot");
  rx_bits_free_a: assert property (rise && bitc_r != ACK_SLOT && (!dat_r || !rw_r) |-> dev_sda_oe_n)
    else $error("line driven while host sends");
  stop_release_a: assert property (stop |-> dev_sda_oe_n [*8])
    else $error("line driven after stop");
  high_stable_a: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
    else $error("data changed while clock high");
  drive_low_only_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("line driven high");
  owned_drive_a: assert property (!dev_sda_oe_n |-> aok_r || (!dat_r && bitc_r == ACK_SLOT))
    else $error("line driven outside own transfer");
endmodule : ioe_monitor

// ===== ioe_bench.sv
// Purpose: Self-checking bench, host and device ends
// Assumes: 25 MHz clock, reset held 20 cycles
// Notes:   Pins resolved from device enables

`timescale 1ns/1ps

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module ioe_bench;
  import ioe_pkg::*;
  logic       clock_i;
  logic       nrst_i;
  logic       req;
  logic       rd;
  logic       keep;
  logic [2:0] da;
  logic [2:0] strap;
  logic [1:0] sel;
  logic [7:0] wd;
  logic [7:0] ext;
  wire        busy;
  wire        done;
  wire        nack;
  wire        intn;
  wire  [7:0] rdat;
  wire  [7:0] po;
  wire  [7:0] poe;
  wire  [7:0] pins = (poe & ext) | (~poe & po);
  int         n_errors;
  int         samples_checked;

  ioe_bus_if bus ();

  ioe_host u_ioe_host (.clock_i(clock_i), .nrst_i(nrst_i), .bus(bus), .req_i(req), .read_i(rd),
    .keep_ptr_i(keep), .dev_addr_i(da), .reg_sel_i(sel), .wdata_i(wd), .busy_o(busy),
    .done_o(done), .nack_o(nack), .rdata_o(rdat));

  ioe_dev u_ioe_dev (.clock_i(clock_i), .nrst_i(nrst_i), .bus(bus), .addr_strap_i(strap),
    .port_i(pins), .port_o(po), .port_oe_n_o(poe), .int_oe_n_o(intn));

  ioe_monitor u_ioe_monitor (.clock_i(clock_i), .nrst_i(nrst_i), .host_scl_o(bus.host_scl_o),
    .host_sda_o(bus.host_sda_o), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .scl(bus.scl), .sda(bus.sda), .addr_strap_i(strap));

  always #20 clock_i = ~clock_i;

  // ****************************************
  // Transfers
  // ****************************************
  task automatic xfer(input logic r, input logic k, input logic [1:0] s, input logic [7:0] w);
    int n;
    req <= 1'b1;
    rd <= r;
    keep <= k;
    sel <= s;
    wd <= w;
    @(posedge clock_i);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (done !== 1'b1 && n < 4000);
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask : xfer

  task automatic rdr(input logic [1:0] s);
    xfer(1'b1, 1'b0, s, 8'h00);
  endtask : rdr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults;
    rdr(SEL_OUTPUT); `CHK(rdat, 8'hff)
    rdr(SEL_INVERT); `CHK(rdat, 8'h00)
    rdr(SEL_DIR); `CHK(rdat, 8'hff)
    `CHK(poe, 8'hff)
    rdr(SEL_INPUT); `CHK(rdat, 8'h5a)
  endtask : t_defaults

  task automatic t_write;
    xfer(1'b0, 1'b0, SEL_OUTPUT, 8'h3c);
    xfer(1'b0, 1'b0, SEL_DIR, 8'h0f);
    `CHK(poe, 8'h0f)
    `CHK(pins, 8'h3a)
    rdr(SEL_INPUT); `CHK(rdat, 8'h3a)
    rdr(SEL_OUTPUT); `CHK(rdat, 8'h3c)
    xfer(1'b0, 1'b0, SEL_INPUT, 8'h00);
    rdr(SEL_OUTPUT); `CHK(rdat, 8'h3c)
    xfer(1'b0, 1'b0, SEL_INVERT, 8'hf0);
    rdr(SEL_INPUT); `CHK(rdat, 8'hca)
    xfer(1'b0, 1'b0, SEL_INVERT, 8'h00);
  endtask : t_write

  task automatic t_keep;
    rdr(SEL_DIR);
    xfer(1'b1, 1'b1, SEL_INPUT, 8'h00); `CHK(rdat, 8'h0f)
    rdr(SEL_INPUT);
    ext <= 8'ha0;
    xfer(1'b1, 1'b1, SEL_INPUT, 8'h00); `CHK(rdat, 8'h30)
  endtask : t_keep

  task automatic t_int;
    `CHK(intn, 1'b1)
    // Low nibble is the input half after the direction write
    ext <= 8'h02;
    repeat (4) @(posedge clock_i);
    `CHK(intn, 1'b0)
    ext <= 8'h00;
    repeat (4) @(posedge clock_i);
    `CHK(intn, 1'b1)
    ext <= 8'h02;
    repeat (4) @(posedge clock_i);
    `CHK(intn, 1'b0)
    xfer(1'b1, 1'b1, SEL_INPUT, 8'h00); `CHK(rdat, 8'h32)
    `CHK(intn, 1'b1)
  endtask : t_int

  task automatic t_addr;
    for (int i = 0; i < 8; i++) begin
      strap <= 3'(i);
      da <= 3'(i);
      rdr(SEL_OUTPUT); `CHK(nack, 1'b0)
      `CHK(rdat, 8'h3c)
      da <= 3'(i) ^ 3'h5;
      xfer(1'b0, 1'b0, SEL_OUTPUT, 8'h00); `CHK(nack, 1'b1)
    end
    da <= 3'h7;
    rdr(SEL_OUTPUT); `CHK(rdat, 8'h3c)
  endtask : t_addr

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (100000) @(posedge clock_i);
    n_errors++;
    report_and_stop();
  end

  initial begin
    clock_i = 1'b0;
    nrst_i = 1'b0;
    req = 1'b0;
    rd = 1'b0;
    keep = 1'b0;
    da = 3'h2;
    strap = 3'h2;
    sel = 2'h0;
    wd = 8'h00;
    ext = 8'h5a;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_defaults();
    t_write();
    t_keep();
    t_int();
    t_addr();
    report_and_stop();
  end
endmodule : ioe_bench
